// ### abr_branch_point.sv
// Branch point of a point-to-multipoint rate-controlled connection.

// Behaviour
// - Copy root cells to every responding branch.
// - Control cells keep arrival order per branch.
// - Emit forward and backward control cells rootward.
// - Rootward cells merge feedback from responding branches.
// - Outgoing flows behave like point-to-point flows.
// - Fewer control cells may go rootward.
// - Generated cell with BN also carries CI/NI.
// - Leaves send no data cells toward root.
// - Path control cells use channel 6, type 110.
// - Channel 6 reserved for path-level control only.
// - Path-level mode passes channel-level control untouched.
// - Any channel 6 cell counts as path control.
// - Path endpoints behave as point-to-point endpoints.
// - Silent branch may become non-responding after timeout.
module abr_branch_point #(
  parameter int SILENCE_CYCLES = abr_bp_pkg::SILENCE_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  abr_bp_if.branch                   bus,
  input  wire logic                  silenceEnable,
  input  wire logic                  vpLevel,
  output logic [abr_bp_pkg::NBR-1:0] responding
);

  localparam int NBR = abr_bp_pkg::NBR;

  // ******************************************
  // Helpers.
  // ******************************************

  // Returns the lowest index whose bit is set.
  function automatic logic [abr_bp_pkg::IDX_W-1:0] firstIdx(input logic [NBR-1:0] v);
    logic [abr_bp_pkg::IDX_W-1:0] r;
    r = '0;
    for (int k = NBR - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = abr_bp_pkg::IDX_W'(k);
      end
    end
    return r;
  endfunction : firstIdx

  logic [NBR-1:0] respond_q;

  assign responding = respond_q;

  // ******************************************
  // Root-to-leaf buffer and replication.
  // ******************************************

  abr_bp_pkg::cell_t buf_q [abr_bp_pkg::BUF_DEPTH];
  logic              wrPtr_q;
  logic              rdPtr_q;
  logic [1:0]        count_q;
  logic [NBR-1:0]    sent_q;

  wire            bufEmpty  = count_q == 2'h0;
  wire            push      = bus.rootValid && bus.rootReady;
  wire [NBR-1:0]  delivered = bus.leafValid & bus.leafReady;
  wire            allDone   = &(sent_q | delivered | ~respond_q);
  wire            pop       = !bufEmpty && allDone;

  assign bus.rootReady = count_q != 2'h2;
  assign bus.leafCell  = buf_q[rdPtr_q];
  assign bus.leafValid = {NBR{!bufEmpty}} & respond_q & ~sent_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
      sent_q  <= '0;
    end else begin
      wrPtr_q <= wrPtr_q ^ push;
      rdPtr_q <= rdPtr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
      sent_q  <= pop ? '0 : (sent_q | delivered);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_q[wrPtr_q] <= bus.rootCell;
    end
  end

  // ******************************************
  // Leaf-to-root selection.
  // ******************************************

  abr_bp_pkg::cell_t outCell_q;
  logic              outValid_q;
  logic [NBR-1:0]    contrib_q [2];

  wire [abr_bp_pkg::IDX_W-1:0] sel     = firstIdx(bus.upValid);
  wire abr_bp_pkg::cell_t      selCell = bus.upCell[sel];
  wire                         isVp    = abr_bp_pkg::isVpRm(selCell);
  wire                         merge   = selCell.isRm && (!vpLevel || isVp);
  wire                         passRm  = selCell.isRm && vpLevel && !isVp;
  wire                         outFree = !outValid_q || bus.toRootReady;
  wire emitFwd = (|contrib_q[0]) && (&(contrib_q[0] | ~respond_q));
  wire emitBwd = (|contrib_q[1]) && (&(contrib_q[1] | ~respond_q));
  wire loadFwd = outFree && emitFwd;
  wire loadBwd = outFree && !emitFwd && emitBwd;
  wire take    = (|bus.upValid) && outFree && !emitFwd && !emitBwd;
  wire mergeIn = take && merge;

  logic [NBR-1:0] upRdy;

  assign bus.upReady     = upRdy;
  assign bus.toRootCell  = outCell_q;
  assign bus.toRootValid = outValid_q;

  // ******************************************
  // Feedback merging, one accumulator per direction.
  // ******************************************

  abr_bp_pkg::cell_t genCell [2];

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_acc
      logic [abr_bp_pkg::ER_W-1:0]  er_q;
      logic                         ci_q;
      logic                         ni_q;
      logic                         bn_q;
      logic [abr_bp_pkg::VCI_W-1:0] vci_q;
      logic [2:0]                   pti_q;

      wire clear = (d == 0) ? loadFwd : loadBwd;
      wire hit   = mergeIn && (selCell.backward == 1'(d));
      wire lower = selCell.er < er_q;

      always_comb begin
        genCell[d]          = '0;
        genCell[d].isRm     = 1'b1;
        genCell[d].backward = 1'(d);
        genCell[d].bn       = bn_q;
        genCell[d].ci       = ci_q;
        genCell[d].ni       = ni_q || (bn_q && !ci_q);
        genCell[d].er       = er_q;
        genCell[d].vci      = vci_q;
        genCell[d].pti      = pti_q;
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          er_q         <= abr_bp_pkg::ER_MAX;
          ci_q         <= 1'b0;
          ni_q         <= 1'b0;
          bn_q         <= 1'b0;
          vci_q        <= '0;
          pti_q        <= '0;
          contrib_q[d] <= '0;
        end else if (clear) begin
          er_q         <= abr_bp_pkg::ER_MAX;
          ci_q         <= 1'b0;
          ni_q         <= 1'b0;
          bn_q         <= 1'b0;
          contrib_q[d] <= '0;
        end else if (hit) begin
          er_q         <= lower ? selCell.er : er_q;
          ci_q         <= ci_q || selCell.ci;
          ni_q         <= ni_q || selCell.ni;
          bn_q         <= bn_q || selCell.bn;
          vci_q        <= selCell.vci;
          pti_q        <= selCell.pti;
          contrib_q[d] <= contrib_q[d] | (NBR'(1) << sel);
        end
      end
    end
  endgenerate

  // ******************************************
  // Rootward output register.
  // ******************************************

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outValid_q <= 1'b0;
      outCell_q  <= '0;
    end else if (loadFwd) begin
      outValid_q <= 1'b1;
      outCell_q  <= genCell[0];
    end else if (loadBwd) begin
      outValid_q <= 1'b1;
      outCell_q  <= genCell[1];
    end else if (take && passRm) begin
      outValid_q <= 1'b1;
      outCell_q  <= selCell;
    end else if (bus.toRootReady) begin
      outValid_q <= 1'b0;
    end
  end

  // ******************************************
  // Per-branch acceptance and silence timing.
  // ******************************************

  genvar i;
  generate
    for (i = 0; i < NBR; i++) begin : g_branch
      logic [abr_bp_pkg::CNT_W-1:0] silent_q;

      // Data cells from leaves are taken and dropped.
      assign upRdy[i] = take && (sel == abr_bp_pkg::IDX_W'(i));

      wire heard  = bus.upValid[i] && upRdy[i] && bus.upCell[i].isRm;
      wire atEnd  = silent_q == abr_bp_pkg::CNT_W'(SILENCE_CYCLES);
      wire [abr_bp_pkg::CNT_W-1:0] silent_d = heard ? '0 :
                                              (atEnd ? silent_q : silent_q + 1'b1);

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          silent_q     <= '0;
          respond_q[i] <= 1'b1;
        end else begin
          silent_q     <= silent_d;
          respond_q[i] <= !silenceEnable ||
                          (silent_d != abr_bp_pkg::CNT_W'(SILENCE_CYCLES));
        end
      end
    end
  endgenerate

endmodule : abr_branch_point

// ### abr_bp_pkg.sv
// Shared types, constants and helpers of the multicast branch point.
package abr_bp_pkg;

  localparam int          NBR            = 4;
  localparam int          IDX_W          = 2;
  localparam int          ER_W           = 16;
  localparam int          VCI_W          = 16;
  localparam int          CNT_W          = 32;
  localparam int          BUF_DEPTH      = 2;
  localparam logic [15:0] VP_RM_VCI      = 16'h0006;
  localparam logic [2:0]  VP_RM_PTI      = 3'h6;
  localparam logic [15:0] ER_MAX         = 16'hffff;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          SILENCE_NS     = 1000000;
  localparam int          SILENCE_CYCLES = (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic             isRm;
    logic             backward;
    logic             bn;
    logic             ci;
    logic             ni;
    logic [ER_W-1:0]  er;
    logic [VCI_W-1:0] vci;
    logic [2:0]       pti;
  } cell_t;

  // Tells whether a cell belongs to path-level resource management.
  function automatic logic isVpRm(input cell_t c);
    return c.vci == VP_RM_VCI;
  endfunction : isVpRm

endpackage : abr_bp_pkg

// ### abr_bp_if.sv
// Interface joining the branch point to its root and leaf neighbours.
interface abr_bp_if;

  abr_bp_pkg::cell_t                  rootCell;
  logic                               rootValid;
  logic                               rootReady;
  abr_bp_pkg::cell_t                  leafCell;
  logic [abr_bp_pkg::NBR-1:0]         leafValid;
  logic [abr_bp_pkg::NBR-1:0]         leafReady;
  abr_bp_pkg::cell_t                  upCell [abr_bp_pkg::NBR];
  logic [abr_bp_pkg::NBR-1:0]         upValid;
  logic [abr_bp_pkg::NBR-1:0]         upReady;
  abr_bp_pkg::cell_t                  toRootCell;
  logic                               toRootValid;
  logic                               toRootReady;

  modport branch (
    input  rootCell, rootValid, leafReady, upCell, upValid, toRootReady,
    output rootReady, leafCell, leafValid, upReady, toRootCell, toRootValid
  );

  modport peer (
    output rootCell, rootValid, leafReady, upCell, upValid, toRootReady,
    input  rootReady, leafCell, leafValid, upReady, toRootCell, toRootValid
  );

endinterface : abr_bp_if

// ### abr_branch_peer.sv
// Root source and leaf endpoints facing the branch point.
module abr_branch_peer (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  abr_bp_if.peer                          bus,
  input  wire abr_bp_pkg::cell_t          srcCell,
  input  wire logic                       srcValid,
  output logic                            srcReady,
  input  wire abr_bp_pkg::cell_t          ansCell [abr_bp_pkg::NBR],
  input  wire logic [abr_bp_pkg::NBR-1:0] ansValid,
  output logic [abr_bp_pkg::NBR-1:0]      ansReady,
  input  wire logic [abr_bp_pkg::NBR-1:0] sinkReady,
  output logic [abr_bp_pkg::NBR-1:0]      leafGot,
  output abr_bp_pkg::cell_t               leafGotCell [abr_bp_pkg::NBR],
  input  wire logic                       rootSinkReady,
  output logic                            rootGot,
  output abr_bp_pkg::cell_t               rootGotCell
);

  // ******************************************
  // Cell coding.
  // ******************************************

  // Gives path-level control cells their reserved payload type.
  function automatic abr_bp_pkg::cell_t vpCode(input abr_bp_pkg::cell_t c);
    abr_bp_pkg::cell_t r;
    r = c;
    if (abr_bp_pkg::isVpRm(c)) begin
      r.pti = abr_bp_pkg::VP_RM_PTI;
    end
    return r;
  endfunction : vpCode

  // ******************************************
  // Root source stage.
  // ******************************************

  abr_bp_pkg::cell_t rootCell_q;
  logic              rootValid_q;
  wire               srcTake = srcValid && srcReady;
  wire               srcKeep = srcCell.isRm || !abr_bp_pkg::isVpRm(srcCell);

  assign srcReady      = !rootValid_q || bus.rootReady;
  assign bus.rootCell  = rootCell_q;
  assign bus.rootValid = rootValid_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rootValid_q <= 1'b0;
      rootCell_q  <= '0;
    end else begin
      if (srcTake && srcKeep) begin
        rootCell_q  <= vpCode(srcCell);
        rootValid_q <= 1'b1;
      end else if (bus.rootReady) begin
        rootValid_q <= 1'b0;
      end
    end
  end

  // ******************************************
  // Leaf endpoints.
  // ******************************************

  abr_bp_pkg::cell_t           upCell_q [abr_bp_pkg::NBR];
  logic [abr_bp_pkg::NBR-1:0]  upValid_q;

  assign bus.leafReady = sinkReady;
  assign bus.upValid   = upValid_q;

  genvar i;
  generate
    for (i = 0; i < abr_bp_pkg::NBR; i++) begin : g_leaf
      wire ansTake = ansValid[i] && ansReady[i];

      assign ansReady[i]   = !upValid_q[i] || bus.upReady[i];
      assign bus.upCell[i] = upCell_q[i];

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          upValid_q[i]   <= 1'b0;
          upCell_q[i]    <= '0;
          leafGot[i]     <= 1'b0;
          leafGotCell[i] <= '0;
        end else begin
          if (ansTake && ansCell[i].isRm) begin
            upCell_q[i]  <= vpCode(ansCell[i]);
            upValid_q[i] <= 1'b1;
          end else if (bus.upReady[i]) begin
            upValid_q[i] <= 1'b0;
          end
          leafGot[i] <= bus.leafValid[i] && sinkReady[i];
          if (bus.leafValid[i] && sinkReady[i]) begin
            leafGotCell[i] <= bus.leafCell;
          end
        end
      end
    end
  endgenerate

  // ******************************************
  // Root sink.
  // ******************************************

  assign bus.toRootReady = rootSinkReady;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rootGot     <= 1'b0;
      rootGotCell <= '0;
    end else begin
      rootGot <= bus.toRootValid && rootSinkReady;
      if (bus.toRootValid && rootSinkReady) begin
        rootGotCell <= bus.toRootCell;
      end
    end
  end

endmodule : abr_branch_peer

// ### abr_bp_properties.sv
// Concurrent checks on the branch point's interface signals.
module abr_bp_properties (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              rootValid,
  input wire logic              rootReady,
  input wire abr_bp_pkg::cell_t leafCell,
  input wire logic [3:0]        leafValid,
  input wire logic [3:0]        leafReady,
  input wire logic [3:0]        upValid,
  input wire logic [3:0]        upReady,
  input wire abr_bp_pkg::cell_t toRootCell,
  input wire logic              toRootValid,
  input wire logic              toRootReady,
  input wire logic [3:0]        responding
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Assertions.
  // ****************************************
  bn_needs_mark_a: assert property (toRootValid && toRootCell.bn |-> toRootCell.ci || toRootCell.ni)
    else $error("bn set without ci or ni");
  leaf_hold_a: assert property ((leafValid & ~leafReady) != 4'h0 |=> $stable(leafCell))
    else $error("leaf cell changed while stalled");
  root_hold_a: assert property (toRootValid && !toRootReady |=> toRootValid && $stable(toRootCell))
    else $error("rootward cell dropped while stalled");
  only_responding_a: assert property ((leafValid & ~responding) == 4'h0)
    else $error("cell offered to silent branch");
  copy_all_a: assert property (rootValid && rootReady && leafValid == 4'h0 && responding != 4'h0 |=> leafValid == responding)
    else $error("cell not copied to every branch");
  path_code_a: assert property (toRootValid && toRootCell.vci == abr_bp_pkg::VP_RM_VCI |-> toRootCell.pti == abr_bp_pkg::VP_RM_PTI)
    else $error("path control cell with wrong type");
  rm_only_a: assert property (toRootValid |-> toRootCell.isRm)
    else $error("data cell sent rootward");
  one_take_a: assert property ($onehot0(upValid & upReady))
    else $error("two branches taken at once");
  cover property (toRootValid && toRootReady && toRootCell.backward);
  cover property (rootValid && !rootReady);
  cover property (responding != 4'hf && leafValid != 4'h0);
endmodule : abr_bp_properties

// ### abr_branch_point_tb.sv
// Testbench joining both ends of the branch point.
module abr_branch_point_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef abr_bp_pkg::cell_t cell_t;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       silenceEnable = 1'b0;
  logic       vpLevel = 1'b0;
  logic [3:0] responding;
  cell_t      srcCell = '0;
  logic       srcValid = 1'b0;
  logic       srcReady;
  cell_t      ansCell [abr_bp_pkg::NBR];
  logic [3:0] ansValid = 4'h0;
  logic [3:0] ansReady;
  logic [3:0] sinkReady = 4'hf;
  logic [3:0] leafGot;
  cell_t      leafGotCell [abr_bp_pkg::NBR];
  logic       rootSinkReady = 1'b1;
  logic       rootGot;
  cell_t      rootGotCell;
  cell_t      lq [4][$];
  cell_t      rq [$];
  int         gotCount = 0;
  int         waitCnt = 0;
  int         err_total = 0;
  int         num_checks = 0;
  abr_bp_if bus ();
  abr_branch_point #(.SILENCE_CYCLES(20)) i_abr_branch_point (.sys_clk, .rst, .bus(bus),
    .silenceEnable, .vpLevel, .responding);
  abr_branch_peer i_abr_branch_peer (.sys_clk, .rst, .bus(bus), .srcCell, .srcValid, .srcReady,
    .ansCell, .ansValid, .ansReady, .sinkReady, .leafGot, .leafGotCell, .rootSinkReady,
    .rootGot, .rootGotCell);
  abr_bp_properties i_abr_bp_properties (.sys_clk, .rst, .rootValid(bus.rootValid),
    .rootReady(bus.rootReady), .leafCell(bus.leafCell), .leafValid(bus.leafValid),
    .leafReady(bus.leafReady), .upValid(bus.upValid), .upReady(bus.upReady),
    .toRootCell(bus.toRootCell), .toRootValid(bus.toRootValid),
    .toRootReady(bus.toRootReady), .responding);
  always #(abr_bp_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (leafGot[i] === 1'b1) begin
        lq[i].push_back(leafGotCell[i]);
        gotCount++;
      end
    end
    if (rootGot === 1'b1) begin
      rq.push_back(rootGotCell);
      gotCount++;
    end
  end
  // ****************************************
  // Helpers.
  // ****************************************
  task automatic end_sim;
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [39:0] seen, input logic [39:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic step;
    @(negedge sys_clk);
    waitCnt++;
    if (waitCnt > 200) begin
      err_total++;
      end_sim();
    end
  endtask : step
  function automatic cell_t mk(logic rm, logic bw, logic bn, logic ci, logic ni,
                               logic [15:0] er, logic [15:0] vci);
    mk = '{rm, bw, bn, ci, ni, er, vci,
           (vci == abr_bp_pkg::VP_RM_VCI) ? abr_bp_pkg::VP_RM_PTI : 3'h0};
  endfunction : mk
  task automatic put(input int i, input cell_t c);
    waitCnt = 0;
    if (i < 0) begin
      srcCell  = c;
      srcValid = 1'b1;
    end else begin
      ansCell[i]  = c;
      ansValid[i] = 1'b1;
    end
    while (((i < 0) ? srcReady : ansReady[i]) !== 1'b1) step();
    @(negedge sys_clk);
    if (i < 0) begin
      srcValid = 1'b0;
    end else begin
      ansValid[i] = 1'b0;
    end
    @(negedge sys_clk);
  endtask : put
  task automatic wait_got(input int n);
    waitCnt = 0;
    while (gotCount < n) step();
  endtask : wait_got
  task automatic do_reset;
    rst           = 1'b1;
    silenceEnable = 1'b0;
    vpLevel       = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    foreach (lq[i]) lq[i].delete();
    rq.delete();
  endtask : do_reset
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic multicast_order;
    cell_t e [3];
    int    b;
    e[0] = mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0001, 16'h0020);
    e[1] = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0021);
    e[2] = mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0003, 16'h0020);
    b = gotCount;
    sinkReady = 4'h3;
    for (int k = 0; k < 3; k++) put(-1, e[k]);
    repeat (3) @(negedge sys_clk);
    chk(bus.rootReady, 1'b0);
    sinkReady = 4'hf;
    wait_got(b + 12);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 3; k++) chk(lq[i][k], e[k]);
    end
  endtask : multicast_order
  task automatic merge_feedback;
    logic [15:0] er [4] = '{16'h0028, 16'h000a, 16'h001e, 16'h0014};
    int          b;
    b = gotCount;
    for (int i = 0; i < 4; i++) put(i, mk(1'b1, 1'b0, 1'b0, i == 2, 1'b0, er[i], 16'h0020));
    for (int i = 0; i < 4; i++) put(i, mk(1'b1, 1'b1, i == 1, 1'b0, 1'b0, er[i], 16'h0020));
    wait_got(b + 2);
    chk(rq[0], mk(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h000a, 16'h0020));
    chk(rq[1], mk(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h000a, 16'h0020));
  endtask : merge_feedback
  task automatic silence_recover;
    cell_t d;
    int    b;
    d = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0030);
    do_reset();
    silenceEnable = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(responding, 4'h0);
    b = gotCount;
    put(1, mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0020));
    wait_got(b + 1);
    chk(rq[0], mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0020));
    chk(responding, 4'h2);
    put(-1, mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0006));
    put(-1, d);
    wait_got(b + 2);
    repeat (3) @(negedge sys_clk);
    chk(lq[1][0], d);
    chk(gotCount, b + 2);
  endtask : silence_recover
  task automatic vp_passthrough;
    cell_t       c;
    logic [15:0] er [4] = '{16'h0030, 16'h0011, 16'h0022, 16'h0044};
    int          b;
    c = mk(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0007, 16'h0021);
    do_reset();
    vpLevel = 1'b1;
    b = gotCount;
    put(0, mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0021));
    put(0, c);
    wait_got(b + 1);
    chk(rq[0], c);
    for (int i = 0; i < 4; i++) begin
      put(i, mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, er[i], 16'h0006));
    end
    wait_got(b + 2);
    chk(rq[1], mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0011, 16'h0006));
  endtask : vp_passthrough
  initial begin
    foreach (ansCell[i]) ansCell[i] = '0;
    do_reset();
    multicast_order();
    do_reset();
    merge_feedback();
    silence_recover();
    vp_passthrough();
    end_sim();
  end
endmodule : abr_branch_point_tb
